// *** src/dump_cmd_pkg.sv ***
// Shared constants for the dump action command handler.
// Assumes a 32-bit host memory word and byte-wide FIFOs toward the media unit.
package dump_cmd_pkg;

  // ---------------------------------------------------------------
  // Command block layout
  // ---------------------------------------------------------------
  localparam logic [31:0] LINK_OFS = 32'h0000_0004;
  localparam logic [31:0] BUF_OFS = 32'h0000_0008;
  localparam int EL_BIT = 31;
  localparam int SUSP_BIT = 30;
  localparam int INT_BIT = 29;
  localparam int CMD_HI = 18;
  localparam int CMD_LO = 16;
  localparam int DONE_BIT = 15;
  localparam int OK_BIT = 13;
  localparam logic [2:0] CMD_DUMP = 3'h6;

  // ---------------------------------------------------------------
  // Dump area layout
  // ---------------------------------------------------------------
  localparam int DUMP_AREA_BYTES = 596;
  localparam logic [5:0] FIFO_BYTES = 6'h26;
  localparam logic [5:0] DUMP_WRITE_BYTES = 6'h2C;
  localparam logic [3:0] DUMP_WORDS = 4'hB;
  localparam logic [5:0] RSVD_BYTE = 6'h26;
  localparam logic [5:0] STATION_B1 = 6'h27;
  localparam logic [5:0] STATION_B2 = 6'h28;
  localparam logic [5:0] STATION_B3 = 6'h29;
  localparam logic [5:0] STATION_B4 = 6'h2A;
  localparam logic [7:0] DUMP_CMD_BYTE = 8'h06;

  // ---------------------------------------------------------------
  // Reset values and unit states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CU_IDLE = 2'h0,
    CU_ACTIVE = 2'h1,
    CU_SUSPENDED = 2'h2
  } cu_state_t;

  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] CNT_RESET = 6'h00;

endpackage : dump_cmd_pkg

// *** src/dump_word_packer.sv ***
// Packs a byte stream into words, first byte in the low lane.
// Assumes the consumer takes a full word before more bytes are offered.
`timescale 1ns/1ps
`default_nettype none

module dump_word_packer #(
  parameter int BYTES = 4
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_data_in,
  output logic byte_ready_out,
  output logic word_valid_out,
  output logic [BYTES*8-1:0] word_data_out,
  input wire logic word_ready_in
);

  localparam int CW = (BYTES > 1) ? $clog2(BYTES) : 1;
  localparam logic [CW-1:0] LAST = CW'(BYTES - 1);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (BYTES < 2) begin : g_bad_bytes
    $error("dump_word_packer needs at least two bytes per word");
  end

  typedef struct packed {
    logic [BYTES*8-1:0] word;
    logic [CW-1:0] cnt;
    logic full;
  } pack_t;

  pack_t s_r;
  pack_t s_nxt;

  // Handshake and word output
  assign byte_ready_out = enable_in && !s_r.full;
  assign word_valid_out = s_r.full;
  assign word_data_out = s_r.word;

  // Next state: lane fill and word release
  always_comb begin
    s_nxt = s_r;
    if (s_r.full && word_ready_in) begin
      s_nxt.full = 1'b0;
    end
    if (byte_valid_in && byte_ready_out) begin
      s_nxt.word[s_r.cnt*8 +: 8] = byte_data_in;
      if (s_r.cnt == LAST) begin
        s_nxt.cnt = '0;
        s_nxt.full = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end
  end

  // State register, frozen while enable is low
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
    end else if (enable_in) begin
      s_r <= s_nxt;
    end
  end

endmodule // dump_word_packer

`default_nettype wire

// *** src/dump_cmd_handler.sv ***
// Dump action command handler of the command unit.
// Assumes a req/ack host memory port, a byte transmit FIFO toward the media
// unit, and a byte status FIFO back from it with a marker flag per byte.
`timescale 1ns/1ps
`default_nettype none

// Function
// - command code 110b selects the dump
// - next block is base plus link field
// - end flag: go idle, raise inactive interrupt
// - suspend flag: suspend, interrupt if configured
// - interrupt flag raises command done interrupt
// - device sets completion flag when finished
// - success flag one means no error
// - buffer word gives dump area offset
// - send dump byte, wait for marker
// - store FIFO bytes before parallel registers
// - write status with completion and success
// - pointers, counters, thresholds, low byte first
// - config bytes, reserved byte, station address
module dump_cmd_handler
  import dump_cmd_pkg::*;
#(
  parameter int DATA_W = 32
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic start_in,
  input wire logic [31:0] cu_base_in,
  input wire logic [31:0] block_offset_in,
  input wire logic cfg_suspend_int_in,
  input wire logic [31:0] station_addr_in,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [31:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  output logic txf_valid_out,
  output logic [7:0] txf_data_out,
  input wire logic txf_ready_in,
  input wire logic stf_valid_in,
  input wire logic [7:0] stf_data_in,
  input wire logic stf_marker_in,
  output logic stf_ready_out,
  output logic busy_out,
  output logic [1:0] cu_state_out,
  output logic [31:0] next_block_addr_out,
  output logic done_out,
  output logic command_done_interrupt_out,
  output logic unit_inactive_interrupt_out
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (DATA_W != 32) begin : g_bad_width
    $error("dump_cmd_handler serves a 32-bit memory word only");
  end

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD_CMD = 8'h02,
    ST_RD_LINK = 8'h04,
    ST_RD_BUF = 8'h08,
    ST_SEND_CMD = 8'h10,
    ST_WAIT_MARK = 8'h20,
    ST_DUMP = 8'h40,
    ST_WR_STAT = 8'h80
  } fsm_t;

  typedef struct packed {
    fsm_t st;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] base;
    logic [31:0] blk;
    logic [31:0] cmd;
    logic [31:0] link_addr;
    logic [31:0] dump_addr;
    logic [5:0] byte_cnt;
    logic [3:0] word_idx;
    cu_state_t cu;
    logic done_p;
    logic cx_p;
    logic cna_p;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic pk_in_valid;
  logic [7:0] pk_in_data;
  logic pk_in_ready;
  logic pk_out_valid;
  logic [31:0] pk_out_data;
  logic pk_out_ready;
  logic from_fifo;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
    add32 = a + b;
  endfunction

  function automatic logic [31:0] status_word(input logic [31:0] cmd, input logic ok);
    logic [31:0] w;
    w = cmd;
    w[DONE_BIT] = 1'b1;
    w[OK_BIT] = ok;
    status_word = w;
  endfunction

  // Parallel-register byte for a dump position
  function automatic logic [7:0] par_byte(input logic [5:0] idx, input logic [31:0] sa);
    case (idx)
      STATION_B1: par_byte = sa[7:0];
      STATION_B2: par_byte = sa[15:8];
      STATION_B3: par_byte = sa[23:16];
      STATION_B4: par_byte = sa[31:24];
      default: par_byte = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Byte packer
  // ---------------------------------------------------------------
  dump_word_packer #(
    .BYTES(4)
  ) u_packer (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .enable_in(enable_in),
    .byte_valid_in(pk_in_valid),
    .byte_data_in(pk_in_data),
    .byte_ready_out(pk_in_ready),
    .word_valid_out(pk_out_valid),
    .word_data_out(pk_out_data),
    .word_ready_in(pk_out_ready)
  );

  assign from_fifo = (s_r.byte_cnt < FIFO_BYTES);

  // FIFO handshakes
  // dump byte out
  assign txf_valid_out = enable_in && (s_r.st == ST_SEND_CMD);
  assign txf_data_out = DUMP_CMD_BYTE;
  assign stf_ready_out = enable_in && ((s_r.st == ST_WAIT_MARK) ||
                         ((s_r.st == ST_DUMP) && from_fifo && pk_in_ready));

  // Registered outputs
  assign mem_req_out = s_r.req;
  assign mem_we_out = s_r.we;
  assign mem_addr_out = s_r.addr;
  assign mem_wdata_out = s_r.wdata;
  assign busy_out = (s_r.st != ST_IDLE);
  assign cu_state_out = s_r.cu;
  assign next_block_addr_out = s_r.link_addr;
  assign done_out = s_r.done_p;
  assign command_done_interrupt_out = s_r.cx_p;
  assign unit_inactive_interrupt_out = s_r.cna_p;

  // ---------------------------------------------------------------
  // Command sequence
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.done_p = 1'b0;
    s_nxt.cx_p = 1'b0;
    s_nxt.cna_p = 1'b0;
    pk_in_valid = 1'b0;
    pk_in_data = 8'h00;
    pk_out_ready = 1'b0;
    case (s_r.st)
      ST_IDLE: begin
        if (start_in) begin
          s_nxt.base = cu_base_in;
          s_nxt.blk = add32(cu_base_in, block_offset_in);
          s_nxt.addr = add32(cu_base_in, block_offset_in);
          s_nxt.req = 1'b1;
          s_nxt.we = 1'b0;
          s_nxt.byte_cnt = CNT_RESET;
          s_nxt.word_idx = 4'h0;
          s_nxt.cu = CU_ACTIVE;
          s_nxt.st = ST_RD_CMD;
        end
      end
      ST_RD_CMD: begin
        if (mem_ack_in) begin
          s_nxt.cmd = mem_rdata_in;
          s_nxt.addr = add32(s_r.blk, LINK_OFS);
          s_nxt.st = ST_RD_LINK;
        end
      end
      ST_RD_LINK: begin
        if (mem_ack_in) begin
          s_nxt.link_addr = add32(s_r.base, mem_rdata_in);
          s_nxt.addr = add32(s_r.blk, BUF_OFS);
          s_nxt.st = ST_RD_BUF;
        end
      end
      ST_RD_BUF: begin
        if (mem_ack_in) begin
          s_nxt.dump_addr = add32(s_r.base, mem_rdata_in);
          if (s_r.cmd[CMD_HI:CMD_LO] == CMD_DUMP) begin
            s_nxt.req = 1'b0;
            s_nxt.st = ST_SEND_CMD;
          end else begin
            s_nxt.we = 1'b1;
            s_nxt.addr = s_r.blk;
            s_nxt.wdata = status_word(s_r.cmd, 1'b0);
            s_nxt.st = ST_WR_STAT;
          end
        end
      end
      ST_SEND_CMD: begin
        if (txf_ready_in) begin
          s_nxt.st = ST_WAIT_MARK;
        end
      end
      ST_WAIT_MARK: begin
        if (stf_valid_in && stf_marker_in) begin
          s_nxt.st = ST_DUMP;
        end
      end
      ST_DUMP: begin
        if (s_r.byte_cnt < DUMP_WRITE_BYTES) begin
          pk_in_valid = enable_in && (from_fifo ? stf_valid_in : 1'b1);
          pk_in_data = from_fifo ? stf_data_in : par_byte(s_r.byte_cnt, station_addr_in);
          if (pk_in_valid && pk_in_ready) begin
            s_nxt.byte_cnt = s_r.byte_cnt + 6'h01;
          end
        end
        if (!s_r.req && pk_out_valid) begin
          s_nxt.req = 1'b1;
          s_nxt.we = 1'b1;
          s_nxt.addr = add32(s_r.dump_addr, {26'h0, s_r.word_idx, 2'h0});
          s_nxt.wdata = pk_out_data;
        end
        if (s_r.req && mem_ack_in) begin
          pk_out_ready = 1'b1;
          s_nxt.req = 1'b0;
          s_nxt.word_idx = s_r.word_idx + 4'h1;
          // status only after last dump word
          if (s_r.word_idx == DUMP_WORDS - 4'h1) begin
            s_nxt.req = 1'b1;
            s_nxt.addr = s_r.blk;
            s_nxt.wdata = status_word(s_r.cmd, 1'b1);
            s_nxt.st = ST_WR_STAT;
          end
        end
      end
      ST_WR_STAT: begin
        if (mem_ack_in) begin
          s_nxt.req = 1'b0;
          s_nxt.we = 1'b0;
          s_nxt.done_p = 1'b1;
          s_nxt.cx_p = s_r.cmd[INT_BIT];
          if (s_r.cmd[EL_BIT]) begin
            s_nxt.cu = CU_IDLE;
            s_nxt.cna_p = 1'b1;
          end else if (s_r.cmd[SUSP_BIT]) begin
            s_nxt.cu = CU_SUSPENDED;
            s_nxt.cna_p = cfg_suspend_int_in;
          end else begin
            s_nxt.cu = CU_ACTIVE;
          end
          s_nxt.st = ST_IDLE;
        end
      end
      default: begin
        s_nxt.req = 1'b0;
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // State register, frozen while enable is low
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cu <= CU_IDLE;
      s_r.addr <= WORD_RESET;
    end else if (enable_in) begin
      s_r <= s_nxt;
    end
  end

endmodule // dump_cmd_handler

`default_nettype wire

// *** test/dump_cmd_handler_asserts.sv ***
// Concurrent checks on the ports of the dump command handler.
// Assumes it is bound into dump_cmd_handler; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module dump_cmd_handler_asserts
  import dump_cmd_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic start_in,
  input wire logic cfg_suspend_int_in,
  input wire logic mem_req_out,
  input wire logic mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic [31:0] mem_wdata_out,
  input wire logic mem_ack_in,
  input wire logic txf_valid_out,
  input wire logic [7:0] txf_data_out,
  input wire logic stf_valid_in,
  input wire logic stf_marker_in,
  input wire logic stf_ready_out,
  input wire logic busy_out,
  input wire logic [1:0] cu_state_out,
  input wire logic done_out,
  input wire logic command_done_interrupt_out,
  input wire logic unit_inactive_interrupt_out
);
  // --------------------------------------------------------------
  // Sequences and properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Marker taken from the status FIFO, then a dump word write
  sequence s_marker;
    stf_valid_in && stf_marker_in && stf_ready_out;
  endsequence
  sequence s_dump_wr;
    mem_req_out && mem_we_out;
  endsequence

  a_req_held_stable: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
    && $stable(mem_wdata_out) && $stable(mem_we_out)) else $error("memory request changed before ack");
  a_start_reads_block: assert property ($rose(busy_out) |-> mem_req_out && !mem_we_out && $past(start_in))
    else $error("start did not begin with a block read");
  a_tx_cmd_byte: assert property (txf_valid_out |-> txf_data_out == DUMP_CMD_BYTE && !mem_req_out)
    else $error("wrong byte or memory busy while sending");
  a_tx_after_reads: assert property ($rose(txf_valid_out) |-> $past(mem_ack_in && !mem_we_out))
    else $error("dump byte sent before the block was read");
  a_marker_then_store: assert property (s_marker |-> ##[1:60] s_dump_wr)
    else $error("no dump write after marker");
  // First cycle only, since the pulse stretches while enable is low
  a_done_after_status: assert property ($rose(done_out) |-> !busy_out && $past(mem_ack_in && mem_we_out
    && mem_wdata_out[DONE_BIT])) else $error("done without completed status write");
  a_cx_with_done: assert property (command_done_interrupt_out |-> done_out)
    else $error("command done interrupt outside completion");
  a_idle_inactive: assert property (done_out && cu_state_out == CU_IDLE |-> unit_inactive_interrupt_out)
    else $error("idle without inactive interrupt");
  a_suspend_cfg: assert property (done_out && cu_state_out == CU_SUSPENDED
    |-> unit_inactive_interrupt_out == $past(cfg_suspend_int_in)) else $error("suspend interrupt wrong");
  a_inactive_state: assert property (unit_inactive_interrupt_out |-> done_out && cu_state_out != CU_ACTIVE)
    else $error("inactive interrupt while active");
endmodule // dump_cmd_handler_asserts

bind dump_cmd_handler dump_cmd_handler_asserts chk (.*);

`default_nettype wire

// *** test/dump_partner.sv ***
// Far side model: host memory with command blocks, and the media unit.
// Assumes word addressing on addr bits 9:2 and one dump per command.
`timescale 1ns/1ps
`default_nettype none

module dump_partner (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic slow_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [31:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic ack_out,
  output logic [31:0] rdata_out,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_ready_out,
  input wire logic st_ready_in,
  output logic st_valid_out,
  output logic [7:0] st_data_out,
  output logic st_marker_out
);
  // room for the whole dump area
  logic [31:0] mem [0:255];
  logic [31:0] last_wa;
  logic [1:0] wait_cnt;
  logic [5:0] seq;
  logic phase;

  // Stalls every other cycle when slow; idle data keeps changing
  assign tx_ready_out = !(slow_in && phase);
  assign st_valid_out = seq != 6'h00 && !(slow_in && phase);
  assign st_marker_out = seq == 6'h02;
  assign st_data_out = st_valid_out ? {2'h0, seq} + 8'h0D : {8{phase}} ^ 8'h3C;

  // Memory answers after a wait; media unit sends junk, marker, 38 bytes
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      wait_cnt <= 2'h0;
      seq <= 6'h00;
      phase <= 1'b0;
      last_wa <= 32'h0000_0000;
    end else begin
      phase <= ~phase;
      if (ack_out || !req_in) begin
        ack_out <= 1'b0;
        wait_cnt <= 2'h0;
        rdata_out <= ~rdata_out;
      end else if (wait_cnt >= (slow_in ? 2'h3 : 2'h0)) begin
        ack_out <= 1'b1;
        rdata_out <= mem[addr_in[9:2]];
        if (we_in) begin
          mem[addr_in[9:2]] <= wdata_in;
          last_wa <= addr_in;
        end
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
        rdata_out <= ~rdata_out;
      end
      // marker only answers the dump byte
      if (seq == 6'h00 && tx_valid_in && tx_ready_out && tx_data_in == 8'h06) begin
        seq <= 6'h01;
      end else if (st_valid_out && st_ready_in) begin
        seq <= (seq == 6'h28) ? 6'h00 : seq + 6'h01;
      end
    end
  end
endmodule // dump_partner

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the dump command handler.
// Assumes the partner model in dump_partner and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dump_cmd_pkg::*;
;
  logic clock_in = 1'b0, rst_b_in = 1'b0, enable_in = 1'b1, start_in = 1'b0, cfg_suspend_int_in = 1'b0, slow = 1'b0;
  logic [31:0] cu_base_in = 32'h100, block_offset_in = 32'h20, station_addr_in = 32'h4433_2211;
  logic mem_req_out, mem_we_out, mem_ack_in, txf_valid_out, txf_ready_in, stf_valid_in, stf_marker_in;
  logic stf_ready_out, busy_out, done_out, command_done_interrupt_out, unit_inactive_interrupt_out;
  logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in, next_block_addr_out;
  logic [7:0] txf_data_out, stf_data_in;
  logic [1:0] cu_state_out;
  int miscompares = 0, cmp_count = 0;

  dump_cmd_handler DUT (.*);
  dump_partner p (.clock_in(clock_in), .rst_b_in(rst_b_in), .slow_in(slow), .req_in(mem_req_out),
    .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in), .tx_valid_in(txf_valid_out), .tx_data_in(txf_data_out),
    .tx_ready_out(txf_ready_in), .st_ready_in(stf_ready_out), .st_valid_out(stf_valid_in),
    .st_data_out(stf_data_in), .st_marker_out(stf_marker_in));

  always #2 clock_in = ~clock_in;

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Dump byte as the media unit and station address provide it
  function automatic logic [7:0] eb(input int i);
    if (i < 38) return 8'h10 + i[7:0];
    if (i > 38 && i < 43) return station_addr_in[8*(i-39) +: 8];
    return 8'h00;
  endfunction

  // Block at 0x120, link 0x80, dump area at base plus 0x40
  task run_block(input logic [31:0] w0, input logic cfg, input logic slw, input logic ok);
    int n;
    for (n = 0; n < 12; n++) p.mem[8'h50 + n] = 32'hDEAD_BEEF;
    p.mem[8'h48] = w0;
    p.mem[8'h49] = 32'h0000_0080;
    p.mem[8'h4A] = 32'h0000_0040;
    cfg_suspend_int_in = cfg;
    slow = slw;
    @(posedge clock_in);
    #1 start_in = 1'b1;
    @(posedge clock_in);
    #1 start_in = 1'b0;
    for (n = 0; n < 3000 && done_out !== 1'b1; n++) begin
      @(posedge clock_in);
      #1;
    end
    chk(done_out, 1'b1);
    chk(p.mem[8'h48], w0 | 32'h0000_8000 | (ok ? 32'h0000_2000 : 32'h0));
    chk(p.last_wa, 32'h120);
    chk(next_block_addr_out, 32'h180);
  endtask

  task chk_dump;
    for (int k = 0; k < 11; k++) begin
      chk(p.mem[8'h50 + k], {eb(4*k+3), eb(4*k+2), eb(4*k+1), eb(4*k)});
    end
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_dump_end;
    run_block(32'hA006_0000, 1'b0, 1'b0, 1'b1);
    chk(command_done_interrupt_out, 1'b1);
    chk(unit_inactive_interrupt_out, 1'b1);
    chk(cu_state_out, CU_IDLE);
    chk_dump();
  endtask

  task t_suspend;
    run_block(32'h4006_0000, 1'b1, 1'b1, 1'b1);
    chk(cu_state_out, CU_SUSPENDED);
    chk(unit_inactive_interrupt_out, 1'b1);
    chk(command_done_interrupt_out, 1'b0);
    chk_dump();
    run_block(32'h4006_0000, 1'b0, 1'b0, 1'b1);
    chk(unit_inactive_interrupt_out, 1'b0);
  endtask

  task t_active;
    run_block(32'h2006_0000, 1'b1, 1'b1, 1'b1);
    chk(cu_state_out, CU_ACTIVE);
    chk(unit_inactive_interrupt_out, 1'b0);
    chk(command_done_interrupt_out, 1'b1);
  endtask

  // Frozen start while disabled, then a code that is not the dump
  task t_other_cmd;
    enable_in = 1'b0;
    start_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1 chk(busy_out, 1'b0);
    start_in = 1'b0;
    enable_in = 1'b1;
    run_block(32'h8005_0000, 1'b0, 1'b0, 1'b0);
    chk(p.mem[8'h50], 32'hDEAD_BEEF);
    chk(unit_inactive_interrupt_out, 1'b1);
  endtask

  task close_out;
    $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    t_dump_end();
    t_suspend();
    t_active();
    t_other_cmd();
    close_out();
  end

  // Watchdog well beyond the few hundred cycles needed
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule // tb_top

`default_nettype wire
